// ==== src/counter_pkg.sv ====
// package: register map, field layout, reset values and carrier types of the presettable counter
package counter_pkg;
   localparam int          COUNT_WIDTH    = 4;
   localparam int          ADDR_WIDTH     = 8;
   localparam int          DATA_WIDTH     = 32;

   localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
   localparam logic [7:0]  PRESET_OFFSET  = 8'h04;
   localparam logic [7:0]  STATUS_OFFSET  = 8'h08;

   localparam int          PAR_EN_BIT     = 0;
   localparam int          TRI_EN_BIT     = 1;
   localparam int          LOAD_N_BIT     = 2;
   localparam int          CLEAR_N_BIT    = 3;
   localparam int          TC_BIT         = 4;

   localparam logic        PAR_EN_RESET   = 1'b0;
   localparam logic        TRI_EN_RESET   = 1'b0;
   localparam logic        LOAD_N_RESET   = 1'b1;
   localparam logic        CLEAR_N_RESET  = 1'b0;
   localparam logic [3:0]  PRESET_RESET   = 4'h0;
   localparam logic [3:0]  COUNT_ZERO     = 4'h0;
   localparam logic [3:0]  COUNT_STEP     = 4'h1;
   localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

   typedef struct packed {
      logic                   sync_clear_n;
      logic                   load_enable_n;
      logic                   trickle_count_enable;
      logic                   parallel_count_enable;
      logic [COUNT_WIDTH-1:0] preset_data_in;
   } counter_ctrl_t;

   typedef struct packed {
      logic [COUNT_WIDTH-1:0] count;
      logic                   tc;
   } core_state_t;

   typedef struct packed {
      counter_ctrl_t          ctrl;
      logic [DATA_WIDTH-1:0]  prdata;
      logic                   pready;
      logic                   pslverr;
   } apb_state_t;
endpackage

// ==== src/counter_core.sv ====
// four-bit synchronous counter core with clear, preset, two count enables and terminal count
`timescale 1ns/1ps
module counter_core (
   input  wire logic                                   pclk,
   input  wire logic                                   presetn,
   input  wire counter_pkg::counter_ctrl_t             ctrl,
   input  wire logic                                   trickle_next,
   output logic [counter_pkg::COUNT_WIDTH-1:0]         count_value_out,
   output logic                                        terminal_count_out
);
   counter_pkg::core_state_t state;
   counter_pkg::core_state_t next_state;
   logic                     count_enable;

   always_comb begin
      next_state   = state;
      count_enable = ctrl.parallel_count_enable & ctrl.trickle_count_enable & ctrl.load_enable_n; // R8
      if (!ctrl.sync_clear_n) begin // R3 R4
         next_state.count = counter_pkg::COUNT_ZERO;
      end else if (!ctrl.load_enable_n) begin // R5 R13
         next_state.count = ctrl.preset_data_in;
      end else if (count_enable) begin // R6 R1
         next_state.count = state.count + counter_pkg::COUNT_STEP;
      end
      // registered copy of count==15 and trickle, as seen after this edge
      next_state.tc = (&next_state.count) & trickle_next; // R9
   end

   // no reset on the count itself: it is defined only by a clear or a preset
   always_ff @(posedge pclk) begin // R2 R10 R14
      state <= next_state;
   end

   assign count_value_out    = state.count;
   assign terminal_count_out = state.tc;

   a_clear_wins: assert property (@(posedge pclk) disable iff (!presetn) // R4
      !ctrl.sync_clear_n |=> count_value_out == 4'h0)
      else $error("clear did not zero the count");
   a_clear_prio: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (!ctrl.sync_clear_n && !ctrl.load_enable_n && ctrl.preset_data_in != 4'h0) |=> count_value_out == 4'h0)
      else $error("preset overrode clear");
   a_load_copy: assert property (@(posedge pclk) disable iff (!presetn) // R5
      (ctrl.sync_clear_n && !ctrl.load_enable_n) |=> count_value_out == $past(ctrl.preset_data_in))
      else $error("preset data not loaded");
   a_count_up: assert property (@(posedge pclk) disable iff (!presetn) // R6
      (ctrl.sync_clear_n && ctrl.load_enable_n && ctrl.parallel_count_enable && ctrl.trickle_count_enable)
      |=> count_value_out == 4'($past(count_value_out) + 4'h1))
      else $error("count did not advance by one");
   a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (count_enable && ctrl.sync_clear_n && count_value_out == 4'hf) |=> count_value_out == 4'h0)
      else $error("count did not wrap from fifteen to zero");
   a_hold_state: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (ctrl.sync_clear_n && ctrl.load_enable_n && !(ctrl.parallel_count_enable && ctrl.trickle_count_enable))
      |=> $stable(count_value_out))
      else $error("count changed while an enable was low");
   a_enable_and: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (ctrl.sync_clear_n && ctrl.load_enable_n && count_value_out != 4'h0) ##1 (count_value_out != $past(count_value_out))
      |-> $past(ctrl.parallel_count_enable) && $past(ctrl.trickle_count_enable))
      else $error("count moved without both enables");
   a_tc_value: assert property (@(posedge pclk) disable iff (!presetn) // R9
      ##1 (terminal_count_out == ((&count_value_out) && ctrl.trickle_count_enable)))
      else $error("terminal count disagrees with state and trickle enable");
endmodule

// ==== src/counter_apb.sv ====
// APB-reachable presettable binary counter: control, preset and status registers around the counter core
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
// Operation
// R1 - counting advances one in binary, fifteen wraps to zero
// R2 - all state bits change together, only on the rising clock edge
// R3 - priority: clear, then preset, then count, then hold
// R4 - clear low at an edge zeroes all outputs, ignoring everything else
// R5 - clear high, preset control low: preset data copied regardless of enables
// R6 - clear and preset high: increment only when both enables high
// R7 - clear and preset high: either enable low holds the state
// R8 - internal enable is parallel AND trickle AND preset control inactive
// R9 - terminal count high when trickle enable high and state is fifteen
// R10 - controls sampled only at the rising edge
// R11 - outside logic must not use terminal count as clock or reset
// R12 - outside logic chains terminal count into later stages' enables
// R13 - bit zero least significant; preset data maps bit for bit
// R14 - count undefined at power-up; no asynchronous initialisation of it
module counter_apb (
   input  wire logic                                   pclk,
   input  wire logic                                   presetn,
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [counter_pkg::ADDR_WIDTH-1:0]     paddr,
   input  wire logic [counter_pkg::DATA_WIDTH-1:0]     pwdata,
   output logic [counter_pkg::DATA_WIDTH-1:0]          prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   output logic [counter_pkg::COUNT_WIDTH-1:0]         count_value_out,
   output logic                                        terminal_count_out
);
   counter_pkg::apb_state_t st;
   counter_pkg::apb_state_t next_st;

   function automatic logic reg_hit(input logic [counter_pkg::ADDR_WIDTH-1:0] addr);
      reg_hit = (addr == counter_pkg::CTRL_OFFSET) || (addr == counter_pkg::PRESET_OFFSET)
                || (addr == counter_pkg::STATUS_OFFSET);
   endfunction

   function automatic logic [counter_pkg::DATA_WIDTH-1:0] read_word(
      input logic [counter_pkg::ADDR_WIDTH-1:0] addr,
      input counter_pkg::counter_ctrl_t         c,
      input logic [counter_pkg::COUNT_WIDTH-1:0] cnt,
      input logic                               tc
   );
      read_word = counter_pkg::DATA_ZERO;
      case (addr)
         counter_pkg::CTRL_OFFSET: begin
            read_word[counter_pkg::PAR_EN_BIT]  = c.parallel_count_enable;
            read_word[counter_pkg::TRI_EN_BIT]  = c.trickle_count_enable;
            read_word[counter_pkg::LOAD_N_BIT]  = c.load_enable_n;
            read_word[counter_pkg::CLEAR_N_BIT] = c.sync_clear_n;
         end
         counter_pkg::PRESET_OFFSET: begin
            read_word[counter_pkg::COUNT_WIDTH-1:0] = c.preset_data_in;
         end
         counter_pkg::STATUS_OFFSET: begin
            read_word[counter_pkg::COUNT_WIDTH-1:0] = cnt;
            read_word[counter_pkg::TC_BIT]          = tc;
         end
         default: begin
            read_word = counter_pkg::DATA_ZERO;
         end
      endcase
   endfunction

   always_comb begin
      next_st         = st;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      // setup phase: answer is prepared for the single access cycle
      if (psel && !penable) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = !reg_hit(paddr);
         next_st.prdata  = read_word(paddr, st.ctrl, count_value_out, terminal_count_out);
      end
      // write lands on the edge that completes the access
      if (psel && penable && st.pready && pwrite) begin
         case (paddr)
            counter_pkg::CTRL_OFFSET: begin
               next_st.ctrl.parallel_count_enable = pwdata[counter_pkg::PAR_EN_BIT];
               next_st.ctrl.trickle_count_enable  = pwdata[counter_pkg::TRI_EN_BIT];
               next_st.ctrl.load_enable_n         = pwdata[counter_pkg::LOAD_N_BIT];
               next_st.ctrl.sync_clear_n          = pwdata[counter_pkg::CLEAR_N_BIT];
            end
            counter_pkg::PRESET_OFFSET: begin
               next_st.ctrl.preset_data_in = pwdata[counter_pkg::COUNT_WIDTH-1:0]; // R13
            end
            default: begin
               next_st.ctrl = st.ctrl;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.ctrl.sync_clear_n          <= counter_pkg::CLEAR_N_RESET;
         st.ctrl.load_enable_n         <= counter_pkg::LOAD_N_RESET;
         st.ctrl.trickle_count_enable  <= counter_pkg::TRI_EN_RESET;
         st.ctrl.parallel_count_enable <= counter_pkg::PAR_EN_RESET;
         st.ctrl.preset_data_in        <= counter_pkg::PRESET_RESET;
         st.prdata                     <= counter_pkg::DATA_ZERO;
         st.pready                     <= 1'b0;
         st.pslverr                    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata  = st.prdata;
   assign pready  = st.pready;
   assign pslverr = st.pslverr;

   // ctrl reaches the core as register levels, changing only on clock edges or at reset; trickle_next is the trickle enable's unregistered next value
   counter_core u_core ( // R10
      .pclk               (pclk),
      .presetn            (presetn),
      .ctrl               (st.ctrl),
      .trickle_next       (next_st.ctrl.trickle_count_enable),
      .count_value_out    (count_value_out),
      .terminal_count_out (terminal_count_out)
   );

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("access phase not answered in one cycle");
   a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == counter_pkg::CTRL_OFFSET)
      |=> st.ctrl.sync_clear_n == $past(pwdata[counter_pkg::CLEAR_N_BIT])
          && st.ctrl.parallel_count_enable == $past(pwdata[counter_pkg::PAR_EN_BIT]))
      else $error("control write not stored");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !reg_hit(paddr)) |=> pslverr && pready)
      else $error("unmapped address not flagged");
endmodule

// ==== tb/apb_master.sv ====
// apb master model standing in for the control logic in front of the counter
`timescale 1ns/1ps
module apb_master (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // terminal count is only read back as data, never used as a clock or a reset
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] rdata, output logic err);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, data};
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer as long as it takes; only the bench timeout ends a hang
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      // released lines show the inverse of their last value
      {psel, penable, paddr, pwdata} <= {1'b0, 1'b0, ~addr, ~data};
   endtask
endmodule

// ==== tb/tb_counter_apb.sv ====
// self-checking bench for the apb counter: reset, load, count, hold, clear and decode
`timescale 1ns/1ps
module tb_counter_apb;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, terminal_count_out;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  count_value_out;
   int          errors = 0, checked = 0, cycles = 0;
   apb_master i_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   counter_apb i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                      .count_value_out(count_value_out), .terminal_count_out(terminal_count_out));
   task automatic give_verdict(input int lost);
      errors += lost;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] val, input logic err);
      logic [31:0] rd;
      logic        e;
      i_master.xfer(wr, addr, val, rd, e);
      check(32'(e), 32'(err), "pslverr");
      if (!wr) check(rd, val, "prdata");
      // the answer is a single-cycle pulse
      #1;
      check(32'(pready), 32'h0000_0000, "pready pulse");
   endtask
   // let the edge's updates land, then compare terminal count and count together
   task automatic pins(input logic [31:0] exp);
      #1;
      check(32'({terminal_count_out, count_value_out}), exp, "outputs");
   endtask
   task automatic test_reset;
      pins(32'h0000_0000);
      bus(1'b0, counter_pkg::CTRL_OFFSET, 32'h0000_0004, 1'b0);
      bus(1'b0, counter_pkg::PRESET_OFFSET, 32'h0000_0000, 1'b0);
   endtask
   task automatic test_load;
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_000B, 1'b0);
      bus(1'b1, counter_pkg::PRESET_OFFSET, 32'h0000_000A, 1'b0);
      bus(1'b0, counter_pkg::STATUS_OFFSET, 32'h0000_000A, 1'b0);
      bus(1'b1, counter_pkg::PRESET_OFFSET, 32'h0000_0005, 1'b0);
      bus(1'b0, counter_pkg::STATUS_OFFSET, 32'h0000_0005, 1'b0);
   endtask
   task automatic test_count;
      logic [3:0] v = 4'hC;
      logic [3:0] upper = 4'h0;
      bus(1'b1, counter_pkg::PRESET_OFFSET, 32'h0000_000C, 1'b0);
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_000F, 1'b0);
      for (int i = 0; i < 20; i++) begin
         pins(32'({v == 4'hF, v}));
         // a following stage whose enables are fed from terminal count
         if (terminal_count_out === 1'b1) upper++;
         @(posedge pclk);
         v++;
      end
      check(32'(upper), 32'h0000_0002, "chained stage");
   endtask
   task automatic test_hold;
      bus(1'b1, counter_pkg::PRESET_OFFSET, 32'h0000_000F, 1'b0);
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_000B, 1'b0);
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_000E, 1'b0);
      bus(1'b0, counter_pkg::STATUS_OFFSET, 32'h0000_001F, 1'b0);
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_000D, 1'b0);
      bus(1'b0, counter_pkg::STATUS_OFFSET, 32'h0000_000F, 1'b0);
   endtask
   task automatic test_clear_decode;
      bus(1'b1, counter_pkg::CTRL_OFFSET, 32'h0000_0003, 1'b0);
      bus(1'b0, counter_pkg::STATUS_OFFSET, 32'h0000_0000, 1'b0);
      bus(1'b0, 8'h0C, 32'h0000_0000, 1'b1);
      bus(1'b1, 8'h01, 32'hFFFF_FFFF, 1'b1);
      bus(1'b1, counter_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, 1'b0);
      bus(1'b0, counter_pkg::CTRL_OFFSET, 32'h0000_0003, 1'b0);
   endtask
   initial forever #20 pclk = ~pclk;
   always @(posedge pclk) if (++cycles == 2000) give_verdict(1);
   initial begin
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_load();
      test_count();
      test_hold();
      test_clear_decode();
      give_verdict(0);
   end
endmodule
